//--- core/cfg_lock_consts.svh
// Constants for the control-module region write-lock block.
// Assumes every file that needs a key or an answer code includes it; the guard makes repeats harmless.
`ifndef CFG_LOCK_CONSTS_SVH
`define CFG_LOCK_CONSTS_SVH
`define NUM_REGIONS 5
`define FIFTH_IDX 3'h4
`define FIFTH_LOCK_KEY 32'h143f832c
`define FIFTH_UNLOCK_KEY 32'h6f361e05
`define RESP_OKAY 2'h0
`define RESP_ERROR 2'h1
`define RESP_BLOCKED 2'h2
`endif

//--- core/cfg_lock_pkg.sv
// Types shared by the region write-lock block.
// Assumes the constants header is on the include path.
`include "cfg_lock_consts.svh"
package cfg_lock_pkg;
  // One bus request as seen by the lock logic.
  typedef struct packed {
    logic valid;
    logic write;
    logic is_lock_reg;
    logic [2:0] region;
    logic [31:0] wdata;
  } lock_req_t;
  // Answer returned for every request.
  typedef struct packed {
    logic valid;
    logic [1:0] resp;
    logic pass_write;
    logic [31:0] rdata;
  } lock_resp_t;
endpackage

//--- core/config_region_write_lock.sv
// Write-lock logic guarding five regions of the control-module register space.
// Assumes an upstream decoder flags lock-register accesses and the region of each access.
// Functional notes
// - Five lock registers, one per region.
// - Writes into locked region are discarded.
// - Register-specific lock key locks region.
// - Different register-specific unlock key unlocks region.
// - Fifth-region locked write returns bus error.
// - Then control module inaccessible until reset.
// - Fifth lock register reads lock key while locked, unlock key while open.
// - Fifth unlock key opens pad registers.
// - Fifth lock key closes fifth region.
`include "cfg_lock_consts.svh"
module config_region_write_lock
  import cfg_lock_pkg::*;
#(
  parameter logic [31:0] LOCK_KEY0 = 32'h00000001, // Arbitrary key values for regions 1-4.
  parameter logic [31:0] LOCK_KEY1 = 32'h00000002,
  parameter logic [31:0] LOCK_KEY2 = 32'h00000003,
  parameter logic [31:0] LOCK_KEY3 = 32'h00000004,
  // Unlock keys of regions one to four; each must differ from its lock key.
  parameter logic [31:0] UNLOCK_KEY0 = 32'h00000011,
  parameter logic [31:0] UNLOCK_KEY1 = 32'h00000012,
  parameter logic [31:0] UNLOCK_KEY2 = 32'h00000013,
  parameter logic [31:0] UNLOCK_KEY3 = 32'h00000014,
  parameter logic [4:0] RESET_LOCKS = 5'h00 // Reset lock state is not defined; open by default.
)(
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire lock_req_t i_req,
  output lock_resp_t o_resp,
  output logic [4:0] o_locked,
  output logic o_hung
);

  // Key decoding is a function because the next-state logic and the checks both need it.
  // Lock key for a given region.
  function automatic logic [31:0] lock_key(input logic [2:0] r);
    case (r)
      3'h0: lock_key = LOCK_KEY0;
      3'h1: lock_key = LOCK_KEY1;
      3'h2: lock_key = LOCK_KEY2;
      3'h3: lock_key = LOCK_KEY3;
      default: lock_key = `FIFTH_LOCK_KEY;
    endcase
  endfunction

  // Unlock key for a given region.
  function automatic logic [31:0] unlock_key(input logic [2:0] r);
    case (r)
      3'h0: unlock_key = UNLOCK_KEY0;
      3'h1: unlock_key = UNLOCK_KEY1;
      3'h2: unlock_key = UNLOCK_KEY2;
      3'h3: unlock_key = UNLOCK_KEY3;
      default: unlock_key = `FIFTH_UNLOCK_KEY;
    endcase
  endfunction

  // Running, or wedged after a locked fifth-region write; only reset leaves the wedge.
  typedef enum {ST_RUN, ST_HUNG} mode_t;

  logic [4:0] locked_reg; // One lock bit per region.
  logic [4:0] locked_next; // Lock bits after this cycle's request.
  mode_t mode_reg; // Whole-module accessibility.
  mode_t mode_next; // Accessibility after this cycle's request.
  logic hung_next; // Next value of the wedged output flag.
  lock_resp_t resp_reg; // Registered answer to the bus.
  lock_resp_t resp_next; // Answer to this cycle's request.
  logic in_range; // Region index names a real region.

  // Indexes past the fifth region are refused before they can touch a lock bit.
  assign in_range = (i_req.region < 3'(`NUM_REGIONS));

  // Next-state logic for lock bits, mode and answer.
  // Defaults hold every lock and give an empty answer when no request is present.
  always_comb
  begin
    locked_next = locked_reg;
    mode_next = mode_reg;
    resp_next = '0;
    if (i_req.valid)
    begin
      resp_next.valid = 1'b1;
      if (mode_reg == ST_HUNG)
      begin
        // Once hung nothing is reachable; every access is refused.
        resp_next.resp = `RESP_BLOCKED;
      end
      else if (!in_range)
      begin
        // Unknown region: answer with an error, no side effect.
        resp_next.resp = `RESP_ERROR;
      end
      else if (i_req.is_lock_reg)
      begin
        resp_next.resp = `RESP_OKAY;
        if (i_req.write)
        begin
          if (i_req.wdata == lock_key(i_req.region))
            locked_next[i_req.region] = 1'b1;
          else if (i_req.wdata == unlock_key(i_req.region))
            locked_next[i_req.region] = 1'b0;
          else
            locked_next[i_req.region] = locked_reg[i_req.region]; // Foreign value.
        end
        else
        begin
          // Open registers answer with their unlock key, so both states are visible.
          resp_next.rdata = locked_reg[i_req.region] ? lock_key(i_req.region)
                                                     : unlock_key(i_req.region);
        end
      end
      else if (i_req.write && locked_reg[i_req.region])
      begin
        // A write to a locked region never reaches the register file.
        resp_next.pass_write = 1'b0;
        if (i_req.region == `FIFTH_IDX)
        begin
          // The fifth region does not drop quietly: it errors and wedges the module.
          resp_next.resp = `RESP_ERROR;
          mode_next = ST_HUNG;
        end
        else
          resp_next.resp = `RESP_OKAY; // Regions one to four drop the write quietly.
      end
      else
      begin
        // Open region or a read: the access goes on to the register file.
        resp_next.resp = `RESP_OKAY;
        resp_next.pass_write = i_req.write;
      end
    end
    // The wedged flag is prepared here so that the output register only copies it.
    hung_next = (mode_next == ST_HUNG);
  end

  // Register every piece of state; the five bits make five lock registers.
  // The reset branch loads constants only, so a release never races a data path.
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      locked_reg <= RESET_LOCKS;
      mode_reg <= ST_RUN;
      resp_reg <= '0;
      o_locked <= RESET_LOCKS;
      o_hung <= 1'b0;
    end
    else
    begin
      locked_reg <= locked_next;
      mode_reg <= mode_next;
      resp_reg <= resp_next;
      o_locked <= locked_next;
      o_hung <= hung_next;
    end
  end

  // The answer leaves straight from its register.
  assign o_resp = resp_reg;

  // Checks on the lock rules; each looks one cycle past the request that it judges, AST_FIFTH_HANG also a second cycle.
  // They watch the request that the bus makes as well as what this module drives.

  AST_LOCKED_DROP: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (i_req.valid && i_req.write && !i_req.is_lock_reg && in_range && !o_hung
     && locked_reg[i_req.region]) |=> !o_resp.pass_write)
    else $error("Write into locked region passed.");
  AST_FIFTH_ERR: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (i_req.valid && i_req.write && !i_req.is_lock_reg && !o_hung
     && i_req.region == `FIFTH_IDX && locked_reg[`FIFTH_IDX])
    |=> (o_resp.resp == `RESP_ERROR && o_hung))
    else $error("Locked fifth-region write gave no error.");
  AST_HUNG_STAYS: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    o_hung |=> o_hung && !o_resp.pass_write)
    else $error("Module left hung state without reset.");
  AST_LOCK_KEY: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (i_req.valid && i_req.write && i_req.is_lock_reg && !o_hung && in_range
     && i_req.wdata == lock_key(i_req.region)) |=> o_locked[$past(i_req.region)])
    else $error("Lock key did not lock.");
  AST_UNLOCK_KEY: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (i_req.valid && i_req.write && i_req.is_lock_reg && !o_hung && in_range
     && i_req.wdata == unlock_key(i_req.region)) |=> !o_locked[$past(i_req.region)])
    else $error("Unlock key did not unlock.");
  AST_OTHER_VAL: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (!(i_req.valid && i_req.write && i_req.is_lock_reg)) |=> $stable(o_locked))
    else $error("Lock state changed without a key write.");
  AST_READ_KEY: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (i_req.valid && !i_req.write && i_req.is_lock_reg && !o_hung
     && i_req.region == `FIFTH_IDX && locked_reg[`FIFTH_IDX])
    |=> o_resp.rdata == `FIFTH_LOCK_KEY)
    else $error("Locked fifth register read wrong value.");
  AST_OPEN_PASS: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (i_req.valid && i_req.write && !i_req.is_lock_reg && !o_hung
     && i_req.region == `FIFTH_IDX && !locked_reg[`FIFTH_IDX]) |=> o_resp.pass_write)
    else $error("Unlocked fifth-region write not passed.");

  // The steps of the fifth-region hazard, named for the checks below.
  // A write into the fifth region while its lock is closed.
  sequence fifth_locked_write_s;
    i_req.valid && i_req.write && !i_req.is_lock_reg && !o_hung
      && i_req.region == `FIFTH_IDX && locked_reg[`FIFTH_IDX];
  endsequence

  // The answer to it: an error, with the module wedged.
  sequence error_and_hang_s;
    o_resp.valid && o_resp.resp == `RESP_ERROR && o_hung;
  endsequence

  // A request that reaches the module while it is wedged.
  sequence request_while_hung_s;
    i_req.valid && o_hung;
  endsequence

  // Once wedged, the module stays so on the following cycle as well.
  AST_FIFTH_HANG: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    fifth_locked_write_s |=> error_and_hang_s ##1 o_hung)
    else $error("Locked fifth-region write did not wedge the module.");
  // Every request to a wedged module is refused, lock registers included.
  AST_HUNG_BLOCKS: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    request_while_hung_s |=> (o_resp.valid && o_resp.resp == `RESP_BLOCKED
      && !o_resp.pass_write))
    else $error("Wedged module answered a request.");
  // A value that is neither key of the addressed register leaves every lock alone.
  AST_FOREIGN_KEY: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (i_req.valid && i_req.write && i_req.is_lock_reg && in_range
     && i_req.wdata != lock_key(i_req.region)
     && i_req.wdata != unlock_key(i_req.region)) |=> $stable(o_locked))
    else $error("Foreign value changed a lock.");
  // The fifth lock key closes the fifth region.
  AST_FIFTH_CLOSE: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (i_req.valid && i_req.write && i_req.is_lock_reg && !o_hung
     && i_req.region == `FIFTH_IDX && i_req.wdata == `FIFTH_LOCK_KEY)
    |=> o_locked[`FIFTH_IDX])
    else $error("Fifth lock key did not close the fifth region.");
  // The fifth unlock key opens the fifth region.
  AST_FIFTH_OPEN: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (i_req.valid && i_req.write && i_req.is_lock_reg && !o_hung
     && i_req.region == `FIFTH_IDX && i_req.wdata == `FIFTH_UNLOCK_KEY)
    |=> !o_locked[`FIFTH_IDX])
    else $error("Fifth unlock key did not open the fifth region.");

endmodule // config_region_write_lock

//--- tb/pad_initiator.sv
// Bus initiator model: issues one lock-block request at a time.
// Assumes the bench calls its tasks from a single process.
`include "cfg_lock_consts.svh"
module pad_initiator
  import cfg_lock_pkg::*;
(
  input wire logic i_clk,
  input wire lock_resp_t i_resp,
  output lock_req_t o_req
);
  timeunit 1ns;
  timeprecision 1ns;
  lock_resp_t rsp; // Answer taken in the cycle it stands.
  initial o_req <= '0;
  // Hold the request one edge, then release it with inverted data.
  task automatic xfer(input logic w, input logic l, input logic [2:0] r, input logic [31:0] d);
    @(posedge i_clk);
    o_req <= '{1'b1, w, l, r, d};
    @(posedge i_clk);
    o_req <= '{1'b0, w, l, r, ~d};
    #1 rsp = i_resp;
  endtask
  // Check the fifth lock, open it if closed, write a pad, close it again.
  task automatic pad_update(input logic [31:0] d, output logic ok);
    xfer(1'b0, 1'b1, 3'h4, 32'h0);
    if (rsp.rdata === `FIFTH_LOCK_KEY)
    begin
      xfer(1'b1, 1'b1, 3'h4, `FIFTH_UNLOCK_KEY);
    end
    xfer(1'b1, 1'b0, 3'h4, d);
    ok = rsp.pass_write;
    xfer(1'b1, 1'b1, 3'h4, `FIFTH_LOCK_KEY);
  endtask
endmodule // pad_initiator

//--- tb/config_region_write_lock_bench.sv
// Self-checking bench for the region write-lock block.
// Assumes the package and the initiator model are compiled first.
`include "cfg_lock_consts.svh"
module config_region_write_lock_bench
  import cfg_lock_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [31:0] LB = 32'h5a5a0010; // Arbitrary key bases.
  localparam logic [31:0] UB = 32'h3c3c0020;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  lock_req_t req;
  lock_resp_t resp;
  logic [4:0] locked;
  logic hung;
  logic ok;
  int err_total = 0;
  int checks = 0;
  always #50 clk = ~clk;
  config_region_write_lock #(.LOCK_KEY0(LB), .LOCK_KEY1(LB + 32'h1),
    .LOCK_KEY2(LB + 32'h2), .LOCK_KEY3(LB + 32'h3), .UNLOCK_KEY0(UB),
    .UNLOCK_KEY1(UB + 32'h1), .UNLOCK_KEY2(UB + 32'h2), .UNLOCK_KEY3(UB + 32'h3),
    .RESET_LOCKS(5'h00)) config_region_write_lock_i (.i_clk(clk), .i_rst_n(rst_n),
    .i_req(req), .o_resp(resp), .o_locked(locked), .o_hung(hung));
  pad_initiator pad_initiator_i (.i_clk(clk), .i_resp(resp), .o_req(req));
  // Compare and count; a mismatch is reported at once.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Reset starts on a clock edge and is held for ten edges.
  task automatic do_reset();
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
  endtask
  // Regions 0-3: lock, dropped write, foreign key, then unlock.
  task automatic t_four();
    for (int r = 0; r < 4; r++)
    begin
      pad_initiator_i.xfer(1'b1, 1'b1, 3'(r), LB + 32'(r));
      chk(32'(locked), 32'(1 << r));
      pad_initiator_i.xfer(1'b1, 1'b0, 3'(r), 32'h7);
      chk({29'h0, pad_initiator_i.rsp.resp, pad_initiator_i.rsp.pass_write}, 32'h0);
      pad_initiator_i.xfer(1'b1, 1'b1, 3'(r), `FIFTH_UNLOCK_KEY);
      chk(32'(locked), 32'(1 << r));
      pad_initiator_i.xfer(1'b1, 1'b1, 3'(r), UB + 32'(r));
      chk(32'(locked), 32'h0);
    end
  endtask
  // Fifth region: read-back, guarded update, locked write hangs.
  task automatic t_fifth();
    pad_initiator_i.xfer(1'b1, 1'b1, 3'h4, `FIFTH_LOCK_KEY);
    chk(32'(locked), 32'h10);
    pad_initiator_i.xfer(1'b0, 1'b1, 3'h4, 32'h0);
    chk(pad_initiator_i.rsp.rdata, `FIFTH_LOCK_KEY);
    pad_initiator_i.pad_update(32'ha5, ok);
    chk(32'(ok), 32'h1);
    chk(32'(locked), 32'h10);
    pad_initiator_i.xfer(1'b1, 1'b0, 3'h4, 32'h1);
    chk(32'(pad_initiator_i.rsp.resp), 32'(`RESP_ERROR));
    chk(32'(hung), 32'h1);
    pad_initiator_i.xfer(1'b1, 1'b1, 3'h0, LB);
    chk(32'(pad_initiator_i.rsp.resp), 32'(`RESP_BLOCKED));
    chk(32'(locked), 32'h10);
  endtask
  // Straight after a release: quiet answer, open locks, and the module reachable again.
  task automatic t_after_reset();
    lock_resp_t r;
    #1 chk({28'h0, resp.valid, resp.resp, resp.pass_write}, 32'h0);
    chk(resp.rdata, 32'h0);
    chk(32'(locked), 32'h0);
    chk(32'(hung), 32'h0);
    pad_initiator_i.xfer(1'b1, 1'b0, `FIFTH_IDX, 32'h3c);
    r = pad_initiator_i.rsp;
    chk({28'h0, r.valid, r.resp, r.pass_write}, {28'h0, 1'b1, `RESP_OKAY, 1'b1});
  endtask
  // Answer format: one-cycle valid, read-back of open registers, open writes, bad region.
  task automatic t_answer();
    pad_initiator_i.xfer(1'b0, 1'b1, 3'h1, 32'h0);
    chk({31'h0, pad_initiator_i.rsp.valid}, 32'h1);
    chk(pad_initiator_i.rsp.rdata, UB + 32'h1);
    @(posedge clk);
    #1 chk({31'h0, resp.valid}, 32'h0);
    pad_initiator_i.xfer(1'b0, 1'b1, `FIFTH_IDX, 32'h0);
    chk(pad_initiator_i.rsp.rdata, `FIFTH_UNLOCK_KEY);
    pad_initiator_i.xfer(1'b1, 1'b0, 3'h2, 32'h5);
    chk({29'h0, pad_initiator_i.rsp.resp, pad_initiator_i.rsp.pass_write}, 32'h1);
    pad_initiator_i.xfer(1'b1, 1'b1, 3'h5, LB);
    chk(32'(pad_initiator_i.rsp.resp), 32'(`RESP_ERROR));
    chk({31'h0, pad_initiator_i.rsp.pass_write}, 32'h0);
    chk(32'(locked), 32'h0);
  endtask
  task automatic wrap_up();
    $display("checks=%0d err_total=%0d", checks, err_total);
    if (err_total == 0 && checks > 0)
    begin
      $display("All tests passed");
    end
    else
    begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial
  begin
    do_reset();
    t_after_reset();
    t_four();
    t_answer();
    t_fifth();
    do_reset();
    #1 chk(32'(hung), 32'h0);
    t_after_reset();
    wrap_up();
  end
endmodule // config_region_write_lock_bench
